/* File: rtl/wft_core.v */
// twelve-bit two-output waveform timer with AHB-Lite register slave
// assumes a single 200 MHz hclk; event inputs arrive asynchronously
//
// Summary of operation
// [R1] counter division is sync times counter prescale
// [R2] cycle phases: dead A, on A, dead B, on B
// [R3] mode field selects one of four schemes
// [R4] one ramp counts to b-clear, then zero
// [R5] one ramp: above b-clear never matches
// [R6] software orders compares to avoid overlap
// [R7] two ramp: up to a-clear, then b-clear
// [R8] two/four ramp outputs never overlap
// [R9] four ramp: four ramps ending at each compare
// [R10] dual slope: down to zero, up again
// [R11] dual slope output set/clear by direction
// [R12] dual slope ignores a-clear register
// [R13] dual slope starts at b-clear, A waits
// [R14] two inputs, only A has blanking
// [R15] trigger enable and capture action bits
// [R16] sync override after 2-3 sync clocks
// [R17] delay select 0x1 enables blanking on A
// [R18] blanking runs on prescaled sync clock
// [R19] software never mixes blanking and delay event
// [R20] filter rejects pulses under four counter clocks
// [R21] asynchronous_detect_enable override direct, counter waits for sync
// [R22] software never sets asynchronous_detect_enable with filter
// [R23] reaction field selects fault behaviour
// [R24] outputs active only in their on-times
`timescale 1ns/10ps
`include "wft_regs.vh"

module wft_core (
    input  wire        hclk,
    input  wire        hresetn,
    input  wire        hsel,
    input  wire [31:0] haddr,
    input  wire [1:0]  htrans,
    input  wire        hwrite,
    input  wire [2:0]  hsize,
    input  wire [31:0] hwdata,
    input  wire        hready,
    output reg         hreadyout,
    output reg         hresp,
    output reg  [31:0] hrdata,
    input  wire        event_in_a,
    input  wire        event_in_b,
    output reg         output_a,
    output reg         output_b
);

    // one-hot cycle phases
    localparam [3:0] P_DTA = 4'b0001;
    localparam [3:0] P_OTA = 4'b0010;
    localparam [3:0] P_DTB = 4'b0100;
    localparam [3:0] P_OTB = 4'b1000;

    // software registers
    reg  [8:0]  ctrl;                   // enable, mode, prescalers
    reg  [11:0] a_set_compare, a_clear_compare, b_set_compare, b_clear_compare;
    reg  [7:0]  evc_a, evc_b;           // input_event_control A and B
    reg  [5:0]  delay_control;
    reg  [7:0]  delay_count_value;
    reg  [11:0] cap_a, cap_b;           // counter captured per input
    reg         restart;                // one-cycle restart strobe

    // bus pipeline
    reg         wr_pend, rd_pend;
    reg  [7:0]  dph_addr;

    // timer state
    reg  [11:0] cnt;
    reg         dir_up;
    reg  [3:0]  phase;
    reg         a_int, b_int, a_int_d, b_int_d;
    reg         first_done;             // dual slope first cycle ended
    reg         halt;                   // stopped until restart
    reg  [2:0]  sdiv, cdiv, ddiv;
    reg         blank;
    reg  [7:0]  dcnt;

    wire        enable = ctrl[`WFT_CTRL_EN];
    wire [1:0]  waveform_mode_select = ctrl[`WFT_CTRL_MODE +: 2];
    wire [1:0]  synchronizer_prescaler = ctrl[`WFT_CTRL_SYNCP +: 2];
    wire [1:0]  counter_prescaler = ctrl[`WFT_CTRL_CNTP +: 2];
    wire [1:0]  delay_function_select = delay_control[`WFT_DLY_SEL +: 2];
    wire [1:0]  delay_trigger_select = delay_control[`WFT_DLY_TRIG +: 2];
    wire [1:0]  delay_prescaler = delay_control[`WFT_DLY_PRESC +: 2];
    wire [15:0] evc_all = {evc_b, evc_a};
    wire [1:0]  ev_raw = {event_in_b, event_in_a};

    // prescaler enables: factors 1, 2, 4, 8 each
    wire sync_en = (sdiv == ((3'h1 << synchronizer_prescaler) - 3'h1));
    wire cnt_en  = sync_en & (cdiv == ((3'h1 << counter_prescaler) - 3'h1));
    wire dly_en  = sync_en & (ddiv == ((3'h1 << delay_prescaler) - 3'h1));

    // prescaler chain; counter divider only advances on sync ticks
    always @(posedge hclk or negedge hresetn) begin
        if (!hresetn) begin
            sdiv <= 3'h0;
            cdiv <= 3'h0;
            ddiv <= 3'h0;
        end else if (!enable) begin
            sdiv <= 3'h0;
            cdiv <= 3'h0;
            ddiv <= 3'h0;
        end else begin
            sdiv <= sync_en ? 3'h0 : sdiv + 3'h1;
            if (sync_en) begin
                cdiv <= cnt_en ? 3'h0 : cdiv + 3'h1; // [R1]
                ddiv <= dly_en ? 3'h0 : ddiv + 3'h1; // [R18]
            end
        end
    end

    // per-input conditioning: synchroniser, filter, sync path
    reg  [1:0] sy1, sy2, sy3;
    reg  [1:0] lvl;                     // agreed input level
    reg  [1:0] filt_q;
    reg  [1:0] sp1, sp2, sp2_d;         // sp2: fault seen in sync domain
    wire [1:0] cond;                    // enabled, filtered, blanked
    wire [1:0] flt_out;                 // fault level steering outputs
    wire [3:0] fsel [0:1];

    genvar i;
    generate
        for (i = 0; i < 2; i = i + 1) begin : g_in
            reg  [2:0] fcnt;
            wire [7:0] evc = evc_all[i*8 +: 8];
            wire       pre = evc[`WFT_EVC_FILTER] ? filt_q[i] : lvl[i];
            assign fsel[i] = evc[`WFT_EVC_FRS +: 4];
            // only input A can be blanked
            assign cond[i] = evc[`WFT_EVC_TRIG] & pre & ~((i == 0) & blank); // [R14] [R15]
            // asynchronous_detect_enable detection bypasses the sync-clock stages
            assign flt_out[i] = evc[`WFT_EVC_ASYNCHRONOUS_DETECT_ENABLE] ? cond[i] : sp2[i]; // [R21]

            // three-flop synchroniser, level taken once stages 2 and 3 agree
            always @(posedge hclk or negedge hresetn) begin
                if (!hresetn) begin
                    sy1[i] <= 1'b0;
                    sy2[i] <= 1'b0;
                    sy3[i] <= 1'b0;
                    lvl[i] <= 1'b0;
                end else begin
                    sy1[i] <= ev_raw[i];
                    sy2[i] <= sy1[i];
                    sy3[i] <= sy2[i];
                    if (sy2[i] == sy3[i])
                        lvl[i] <= sy3[i];
                end
            end

            // glitch filter: new level must hold four counter clocks
            always @(posedge hclk or negedge hresetn) begin
                if (!hresetn) begin
                    fcnt      <= 3'h0;
                    filt_q[i] <= 1'b0;
                end else if (lvl[i] == filt_q[i]) begin
                    fcnt <= 3'h0;
                end else if (cnt_en) begin
                    if (fcnt == `WFT_FILT_LAST) begin // [R20]
                        filt_q[i] <= lvl[i];
                        fcnt      <= 3'h0;
                    end else begin
                        fcnt <= fcnt + 3'h1;
                    end
                end
            end

            // two sync-clock stages give the 2-3 cycle processing delay
            always @(posedge hclk or negedge hresetn) begin
                if (!hresetn) begin
                    sp1[i]   <= 1'b0;
                    sp2[i]   <= 1'b0;
                    sp2_d[i] <= 1'b0;
                end else begin
                    sp2_d[i] <= sp2[i];
                    if (sync_en) begin
                        sp1[i] <= cond[i]; // [R16]
                        sp2[i] <= sp1[i];
                    end
                end
            end
        end
    endgenerate

    // reaction class: 0 none, 1 own output, 2 both outputs, 3 halt
    function [1:0] react;
        input [3:0] code;
        begin
            if (code == `WFT_FRS_NONE || code > `WFT_FRS_MAX)
                react = 2'd0;
            else if (code == `WFT_FRS_HALT)
                react = 2'd3;
            else if (code >= `WFT_FRS_BOTH_LO && code <= `WFT_FRS_BOTH_HI)
                react = 2'd2;
            else
                react = 2'd1;
        end
    endfunction

    wire [1:0] k_a = react(fsel[0]);    // [R23]
    wire [1:0] k_b = react(fsel[1]);
    wire all_off = (flt_out[0] & k_a[1]) | (flt_out[1] & k_b[1]);
    wire ovr_a = all_off | (flt_out[0] & (k_a == 2'd1));
    wire ovr_b = all_off | (flt_out[1] & (k_b == 2'd1));
    // halting follows only the synchronised event
    wire halt_req = (sp2[0] & (k_a == 2'd3)) | (sp2[1] & (k_b == 2'd3)); // [R21]

    // counter and waveform next state
    reg  [11:0] next_cnt;
    reg  [3:0]  next_phase;
    reg         next_dir, next_a, next_b, next_first;
    reg         rend;                   // current ramp ends
    reg  [11:0] rtop;                   // top of current ramp

    always @* begin
        next_cnt   = cnt + 12'h001;
        next_phase = phase;
        next_dir   = dir_up;
        next_a     = a_int;
        next_b     = b_int;
        next_first = first_done;
        rend       = 1'b0;
        rtop       = b_clear_compare;
        case (waveform_mode_select) // [R3]
            `WFT_MODE_ONE: begin
                rend = (cnt == b_clear_compare); // [R4]
                if (rend)
                    next_cnt = 12'h000;
                // compares above b-clear are never reached
                if (cnt == a_set_compare)
                    next_a = 1'b1; // [R5]
                else if (cnt == a_clear_compare && a_clear_compare > a_set_compare)
                    next_a = 1'b0; // [R5]
                if (cnt == b_set_compare)
                    next_b = 1'b1;
                else if (rend)
                    next_b = 1'b0;
                // phase tracks the same matches for the status register
                if (rend)
                    next_phase = P_DTA; // [R2]
                else if (phase == P_DTA && cnt == a_set_compare)
                    next_phase = P_OTA;
                else if (phase == P_OTA && cnt == a_clear_compare)
                    next_phase = P_DTB;
                else if (phase == P_DTB && cnt == b_set_compare)
                    next_phase = P_OTB;
            end
            `WFT_MODE_TWO: begin
                rtop = (phase[0] | phase[1]) ? a_clear_compare : b_clear_compare;
                rend = (cnt == rtop); // [R7]
                if (rend) begin
                    next_cnt   = 12'h000;
                    next_phase = (phase[0] | phase[1]) ? P_DTB : P_DTA;
                end else if (phase == P_DTA && cnt == a_set_compare) begin
                    next_phase = P_OTA;
                end else if (phase == P_DTB && cnt == b_set_compare) begin
                    next_phase = P_OTB;
                end
                next_a = (next_phase == P_OTA); // [R8] [R24]
                next_b = (next_phase == P_OTB);
            end
            `WFT_MODE_FOUR: begin
                case (phase)
                    P_DTA:   rtop = a_set_compare;
                    P_OTA:   rtop = a_clear_compare;
                    P_DTB:   rtop = b_set_compare;
                    default: rtop = b_clear_compare;
                endcase
                rend = (cnt == rtop); // [R9]
                if (rend) begin
                    next_cnt   = 12'h000;
                    next_phase = {phase[2:0], phase[3]}; // [R2]
                end
                next_a = (next_phase == P_OTA); // [R8] [R24]
                next_b = (next_phase == P_OTB);
            end
            default: begin
                // dual slope: zero and top each held for two clocks
                if (!dir_up) begin
                    next_cnt = cnt - 12'h001;
                    if (cnt == 12'h000) begin
                        next_cnt = cnt;
                        next_dir = 1'b1; // [R10]
                    end
                    if (cnt == a_set_compare)
                        next_a = 1'b0; // [R11]
                    if (cnt == b_set_compare)
                        next_b = 1'b1; // [R11]
                end else begin
                    if (cnt == b_clear_compare) begin
                        next_cnt   = cnt;
                        next_dir   = 1'b0; // [R10]
                        next_first = 1'b1;
                        rend       = 1'b1;
                    end
                    // a-clear never consulted here
                    if (cnt == a_set_compare && first_done)
                        next_a = 1'b1; // [R11] [R12] [R13]
                    if (cnt == b_set_compare)
                        next_b = 1'b0; // [R11]
                end
                next_phase = next_a ? P_OTA : (next_b ? P_OTB : P_DTA);
            end
        endcase
    end

    // timer registers
    always @(posedge hclk or negedge hresetn) begin
        if (!hresetn) begin
            cnt        <= 12'h000;
            dir_up     <= 1'b0;
            phase      <= P_DTA;
            a_int      <= 1'b0;
            b_int      <= 1'b0;
            first_done <= 1'b0;
            halt       <= 1'b0;
        end else if (!enable || restart) begin
            // dual slope starts from the top counting down
            cnt        <= (waveform_mode_select == `WFT_MODE_DUAL) ?
                          b_clear_compare : 12'h000; // [R13]
            dir_up     <= 1'b0;
            phase      <= P_DTA;
            a_int      <= 1'b0;
            b_int      <= 1'b0;
            first_done <= 1'b0;
            halt       <= halt_req;
        end else begin
            if (halt_req)
                halt <= 1'b1;
            if (cnt_en && !halt && !halt_req) begin
                cnt        <= next_cnt;
                dir_up     <= next_dir;
                phase      <= next_phase;
                a_int      <= next_a;
                b_int      <= next_b;
                first_done <= next_first;
            end
        end
    end

    // output stage; override is a plain gate ahead of the flop
    always @(posedge hclk or negedge hresetn) begin
        if (!hresetn) begin
            output_a <= 1'b0;
            output_b <= 1'b0;
            a_int_d  <= 1'b0;
            b_int_d  <= 1'b0;
        end else begin
            a_int_d  <= a_int;
            b_int_d  <= b_int;
            output_a <= a_int & ~ovr_a & ~halt; // [R16] [R24]
            output_b <= b_int & ~ovr_b & ~halt;
        end
    end

    // blanking trigger: chosen edge of an internal output
    reg blank_trig;
    always @* begin
        case (delay_trigger_select)
            2'd0:    blank_trig = a_int & ~a_int_d;
            2'd1:    blank_trig = ~a_int & a_int_d;
            2'd2:    blank_trig = b_int & ~b_int_d;
            default: blank_trig = ~b_int & b_int_d;
        endcase
    end

    // blanking window on input A, measured in delay clocks
    always @(posedge hclk or negedge hresetn) begin
        if (!hresetn) begin
            blank <= 1'b0;
            dcnt  <= 8'h00;
        end else if (delay_function_select != `WFT_DLY_BLANK || !enable) begin
            blank <= 1'b0;
            dcnt  <= 8'h00;
        end else if (blank_trig) begin
            blank <= 1'b1; // [R17]
            dcnt  <= 8'h00;
        end else if (blank && dly_en) begin
            dcnt <= dcnt + 8'h01;
            if (dcnt + 8'h01 >= delay_count_value)
                blank <= 1'b0; // [R18]
        end
    end

    // capture on the synchronised rising edge when action is set
    always @(posedge hclk or negedge hresetn) begin
        if (!hresetn) begin
            cap_a <= 12'h000;
            cap_b <= 12'h000;
        end else begin
            if (sp2[0] & ~sp2_d[0] & evc_a[`WFT_EVC_ACTION])
                cap_a <= cnt; // [R15]
            if (sp2[1] & ~sp2_d[1] & evc_b[`WFT_EVC_ACTION])
                cap_b <= cnt;
        end
    end

    // read mux, sampled one cycle after the address phase
    reg [31:0] rd_mux;
    always @* begin
        case (dph_addr)
            `WFT_ADDR_CTRL: rd_mux = {24'h0, ctrl[7:0]};
            `WFT_ADDR_ASET: rd_mux = {20'h0, a_set_compare};
            `WFT_ADDR_ACLR: rd_mux = {20'h0, a_clear_compare};
            `WFT_ADDR_BSET: rd_mux = {20'h0, b_set_compare};
            `WFT_ADDR_BCLR: rd_mux = {20'h0, b_clear_compare};
            `WFT_ADDR_EVCA: rd_mux = {24'h0, evc_a};
            `WFT_ADDR_EVCB: rd_mux = {24'h0, evc_b};
            `WFT_ADDR_DLYC: rd_mux = {26'h0, delay_control};
            `WFT_ADDR_DLYV: rd_mux = {24'h0, delay_count_value};
            `WFT_ADDR_STAT: rd_mux = {12'h0, blank, halt, output_b, output_a,
                                      phase, cnt};
            `WFT_ADDR_CAPA: rd_mux = {20'h0, cap_a};
            `WFT_ADDR_CAPB: rd_mux = {20'h0, cap_b};
            default:        rd_mux = 32'h0000_0000;
        endcase
    end

    // AHB-Lite slave: writes zero-wait, reads one wait state
    wire acc = hsel & hready & htrans[1];
    always @(posedge hclk or negedge hresetn) begin
        if (!hresetn) begin
            hreadyout <= 1'b1;
            hresp <= 1'b0;
            hrdata <= 32'h0000_0000;
            wr_pend <= 1'b0;
            rd_pend <= 1'b0;
            dph_addr <= 8'h00;
            ctrl <= `WFT_CTRL_RST;
            a_set_compare <= `WFT_CMP_RST;
            a_clear_compare <= `WFT_CMP_RST;
            b_set_compare <= `WFT_CMP_RST;
            b_clear_compare <= `WFT_CMP_RST;
            evc_a <= `WFT_EVC_RST;
            evc_b <= `WFT_EVC_RST;
            delay_control <= `WFT_DLYC_RST;
            delay_count_value <= `WFT_DLYV_RST;
            restart <= 1'b0;
        end else begin
            restart <= 1'b0;
            // read data phase ends with registered data
            if (rd_pend) begin
                hrdata    <= rd_mux;
                hreadyout <= 1'b1;
                rd_pend   <= 1'b0;
            end
            if (wr_pend) begin
                wr_pend <= 1'b0;
                case (dph_addr)
                    `WFT_ADDR_CTRL: begin
                        ctrl    <= {1'b0, hwdata[7:0]};
                        restart <= hwdata[`WFT_CTRL_RESTART];
                    end
                    `WFT_ADDR_ASET: a_set_compare   <= hwdata[11:0];
                    `WFT_ADDR_ACLR: a_clear_compare <= hwdata[11:0];
                    `WFT_ADDR_BSET: b_set_compare   <= hwdata[11:0];
                    `WFT_ADDR_BCLR: b_clear_compare <= hwdata[11:0];
                    `WFT_ADDR_EVCA: evc_a <= hwdata[7:0];
                    `WFT_ADDR_EVCB: evc_b <= hwdata[7:0];
                    `WFT_ADDR_DLYC: delay_control     <= hwdata[5:0];
                    `WFT_ADDR_DLYV: delay_count_value <= hwdata[7:0];
                    default: ;      // unmapped or read-only: ignored
                endcase
            end
            if (acc) begin
                dph_addr <= {haddr[7:2], 2'b00};
                wr_pend  <= hwrite & (hsize == 3'b010);
                if (!hwrite) begin
                    rd_pend   <= 1'b1;
                    hreadyout <= 1'b0;
                end
            end
        end
    end

endmodule // wft_core

/* File: rtl/wft_regs.vh */
// register map, field positions, codes and reset values of the waveform timer
// assumes a 32-bit AHB-Lite slave decoding haddr[7:0] on word boundaries
`ifndef WFT_REGS_VH
`define WFT_REGS_VH
// byte offsets
`define WFT_ADDR_CTRL    8'h00
`define WFT_ADDR_ASET    8'h04
`define WFT_ADDR_ACLR    8'h08
`define WFT_ADDR_BSET    8'h0C
`define WFT_ADDR_BCLR    8'h10
`define WFT_ADDR_EVCA    8'h14
`define WFT_ADDR_EVCB    8'h18
`define WFT_ADDR_DLYC    8'h1C
`define WFT_ADDR_DLYV    8'h20
`define WFT_ADDR_STAT    8'h24
`define WFT_ADDR_CAPA    8'h28
`define WFT_ADDR_CAPB    8'h2C
// main control fields
`define WFT_CTRL_EN      0
`define WFT_CTRL_MODE    1
`define WFT_CTRL_SYNCP   4
`define WFT_CTRL_CNTP    6
`define WFT_CTRL_RESTART 8
// waveform modes
`define WFT_MODE_ONE     2'h0
`define WFT_MODE_TWO     2'h1
`define WFT_MODE_FOUR    2'h2
`define WFT_MODE_DUAL    2'h3
// input event control fields
`define WFT_EVC_TRIG     0
`define WFT_EVC_ACTION   1
`define WFT_EVC_FILTER   2
`define WFT_EVC_ASYNCHRONOUS_DETECT_ENABLE    3
`define WFT_EVC_FRS      4
// fault reaction codes
`define WFT_FRS_NONE     4'h0
`define WFT_FRS_BOTH_LO  4'h4
`define WFT_FRS_BOTH_HI  4'h6
`define WFT_FRS_HALT     4'h7
`define WFT_FRS_MAX      4'hA
// delay control fields
`define WFT_DLY_SEL      0
`define WFT_DLY_TRIG     2
`define WFT_DLY_PRESC    4
`define WFT_DLY_BLANK    2'h1
// filter length in counter clocks, minus one
`define WFT_FILT_LAST    3'h3
// reset values
`define WFT_CTRL_RST     9'h000
`define WFT_CMP_RST      12'h000
`define WFT_EVC_RST      8'h00
`define WFT_DLYC_RST     6'h00
`define WFT_DLYV_RST     8'h00
`endif

/* File: tb/wft_core_asserts.sv */
// port checker for the waveform timer core
// assumes hready is looped back from hreadyout
`timescale 1ns/10ps
module wft_core_asserts (
    input wire        hclk,
    input wire        hresetn,
    input wire        hsel,
    input wire [31:0] haddr,
    input wire [1:0]  htrans,
    input wire        hwrite,
    input wire [31:0] hwdata,
    input wire        hready,
    input wire        hreadyout,
    input wire        hresp,
    input wire [31:0] hrdata,
    input wire        output_a,
    input wire        output_b
);
    wire       acc = hsel & hready & htrans[1]; // accepted request
    reg  [5:0] rd_idx;                          // word of the last read
    reg        wr_ctl;                          // control write in data phase
    reg  [2:0] ctl;                             // mode and enable as written
    // shadow of the control word, enough to know the mode
    always @(posedge hclk or negedge hresetn) begin
        if (!hresetn) begin
            rd_idx <= 6'h00;
            wr_ctl <= 1'b0;
            ctl    <= 3'h0;
        end else begin
            if (acc && !hwrite) rd_idx <= haddr[7:2];
            if (wr_ctl) ctl <= hwdata[2:0];
            wr_ctl <= acc && hwrite && haddr[7:2] == 6'h00;
        end
    end
    default clocking cb @(posedge hclk);
    endclocking
    default disable iff (!hresetn);
    resp_okay_a: assert property (!hresp) else $error("hresp not okay");
    read_wait_a: assert property (acc && !hwrite |-> ##[1:2] !hreadyout)
        else $error("read without wait");
    write_fast_a: assert property (acc && hwrite |=> hreadyout)
        else $error("write waited");
    wait_once_a: assert property ($fell(hreadyout) |=> hreadyout)
        else $error("wait too long");
    data_hold_a: assert property (!$rose(hreadyout) |-> $stable(hrdata))
        else $error("hrdata moved");
    unmapped_zero_a: assert property ($rose(hreadyout) && rd_idx > 6'h0B |-> hrdata == 32'h0)
        else $error("unmapped read not zero");
    no_overlap_a: assert property (ctl[2:1] == 2'h1 || ctl[2:1] == 2'h2 |->
        !(output_a && output_b)) else $error("outputs overlap");
    off_quiet_a: assert property ((!ctl[0]) [*3] |-> !output_a && !output_b)
        else $error("outputs active while off");
endmodule // wft_core_asserts
bind wft_core wft_core_asserts i_wft_core_asserts (.*);

/* File: tb/wft_core_tb_top.sv */
// bench for the waveform timer core
// assumes the event network model and a looped-back hready
`timescale 1ns/10ps
`include "wft_regs.vh"
module wft_core_tb_top;
    logic        hclk = 1'b0;
    logic        hresetn = 1'b0;
    logic        hsel = 1'b0;
    logic [31:0] haddr = 32'h0;
    logic [1:0]  htrans = 2'h0;
    logic        hwrite = 1'b0;
    logic [31:0] hwdata = 32'h0;
    logic [1:0]  req = 2'h0;  // event levels into the network
    logic        slow = 1'b0; // network takes the long route
    logic [31:0] q;           // last read word
    wire  [31:0] hrdata;
    wire  [1:0]  ev;
    wire         hreadyout, hresp, output_a, output_b;
    int          error_cnt = 0;
    int          comparisons = 0;
    wft_core i_wft_core (.hclk(hclk), .hresetn(hresetn), .hsel(hsel), .haddr(haddr),
        .htrans(htrans), .hwrite(hwrite), .hsize(3'h2), .hwdata(hwdata),
        .hready(hreadyout), .hreadyout(hreadyout), .hresp(hresp), .hrdata(hrdata),
        .event_in_a(ev[0]), .event_in_b(ev[1]), .output_a(output_a), .output_b(output_b));
    wft_evnet i_wft_evnet (.hclk(hclk), .slow(slow), .req(req), .ev(ev));
    initial begin
        forever #2.5 hclk = ~hclk;
    end
    task automatic check(input string what, input logic [31:0] seen, input logic [31:0] exp);
        comparisons++;
        if (seen !== exp) begin
            error_cnt++;
            $display("BAD %s exp %h seen %h", what, exp, seen);
        end
    endtask
    task automatic final_report;
        if (error_cnt == 0 && comparisons > 0) $display("DONE - PASS");
        else $display("DONE - FAIL");
        $finish;
    endtask
    // next edge with hready seen high, bounded
    task automatic step;
        int n = 0;
        do begin
            @(posedge hclk);
            n++;
        end while (hreadyout !== 1'b1 && n < 20);
        if (hreadyout !== 1'b1) begin
            error_cnt++;
            final_report();
        end
    endtask
    // one single word transfer, address then data phase
    task automatic bus(input logic w, input logic [7:0] a, input logic [31:0] d);
        hsel <= 1'b1;
        haddr <= {24'h0, a};
        htrans <= 2'h2;
        hwrite <= w;
        step();
        hsel <= 1'b0;
        htrans <= 2'h0;
        hwdata <= d;
        step();
        q = hrdata;
    endtask
    task automatic watch(input int n, output int ha, output int hb);
        ha = 0;
        hb = 0;
        repeat (n) begin
            @(posedge hclk);
            ha += (output_a === 1'b1);
            hb += (output_b === 1'b1);
        end
    endtask
    task automatic t_regs;
        for (int a = 0; a < 48; a += 4) begin
            if (a != 36) begin
                bus(1'b0, a[7:0], 32'h0);
                check("reset", q, 32'h0);
            end
        end
        bus(1'b1, `WFT_ADDR_CAPA, 32'h123);
        bus(1'b0, `WFT_ADDR_CAPA, 32'h0);
        check("capa", q, 32'h0);
        bus(1'b0, 8'h40, 32'h0);
        check("unmapped", q, 32'h0);
    endtask
    // restart in a mode, then time output a between rises
    task automatic t_wave(input logic [8:0] ctl, input int p, input int h);
        int e = 0, c = 0, hi = 0, prev = 1;
        bus(1'b1, `WFT_ADDR_CTRL, 32'h0);
        bus(1'b1, `WFT_ADDR_CTRL, {23'h0, ctl});
        for (int n = 0; n < 400 && e < 2; n++) begin
            @(posedge hclk);
            c += (e == 1);
            hi += (e == 1 && output_a === 1'b1);
            if (output_a === 1'b1 && prev == 0) e++;
            prev = (output_a === 1'b1);
        end
        check("period", c, p);
        check("high", hi, h);
        if (e < 2) begin
            error_cnt++;
            final_report();
        end
    endtask
    // hold an event for lat plus 40 cycles, count the last 40
    task automatic t_event(input logic [7:0] evc, input logic [1:0] which, input int lat,
                           input int ea, input int eb);
        int ha, hb;
        bus(1'b1, `WFT_ADDR_EVCA, {24'h0, evc});
        bus(1'b1, `WFT_ADDR_EVCB, {24'h0, evc});
        req <= which;
        watch(lat, ha, hb);
        watch(40, ha, hb);
        req <= 2'h0;
        check("out a", ha, ea);
        check("out b", hb, eb);
        watch(20, ha, hb);
    endtask
    task automatic t_rest;
        int ha, hb;
        bus(1'b1, `WFT_ADDR_BSET, 32'hC);
        watch(20, ha, hb);
        watch(40, ha, hb);
        check("b above", hb, 0);
        bus(1'b1, `WFT_ADDR_BSET, 32'h7);
        slow <= 1'b1;
        t_event(8'h71, 2'h1, 12, 0, 0);
        watch(40, ha, hb);
        check("halted", ha + hb, 0);
        bus(1'b1, `WFT_ADDR_CTRL, 32'h101);
        watch(40, ha, hb);
        check("restart", ha, 12);
        bus(1'b1, `WFT_ADDR_EVCA, 32'h75);
        req <= 2'h1;
        watch(3, ha, hb);
        req <= 2'h0;
        watch(20, ha, hb);
        watch(40, ha, hb);
        check("glitch", ha, 12);
    endtask
    initial begin
        repeat (5) @(posedge hclk);
        hresetn <= 1'b1;
        t_regs();
        bus(1'b1, `WFT_ADDR_ASET, 32'h2);
        bus(1'b1, `WFT_ADDR_ACLR, 32'h5);
        bus(1'b1, `WFT_ADDR_BSET, 32'h7);
        bus(1'b1, `WFT_ADDR_BCLR, 32'h9);
        t_wave(9'h091, 80, 24);
        t_wave(9'h003, 16, 3);
        t_wave(9'h005, 27, 6);
        t_wave(9'h007, 20, 15);
        t_wave(9'h001, 10, 3);
        t_event(8'h40, 2'h1, 10, 12, 8);
        t_event(8'h41, 2'h1, 10, 0, 0);
        t_event(8'h41, 2'h2, 10, 0, 0);
        t_event(8'h49, 2'h1, 8, 0, 0);
        t_event(8'h11, 2'h1, 10, 0, 8);
        t_event(8'hB1, 2'h1, 10, 12, 8);
        t_rest();
        final_report();
    end
endmodule // wft_core_tb_top

/* File: tb/wft_evnet.sv */
// event network model feeding the two timer inputs
// assumes request levels change just after a rising edge
`timescale 1ns/10ps
module wft_evnet (
    input  wire        hclk,
    input  wire        slow,
    input  wire  [1:0] req,
    output logic [1:0] ev = 2'h0
);
    logic [1:0] hop = 2'h0; // extra routing stage
    // slow route adds one cycle of latency
    always @(posedge hclk) begin
        hop <= req;
        ev  <= slow ? hop : req;
    end
endmodule // wft_evnet
